// ==== hdl/jlt_lmfc_timing.sv ====
// multiframe clock and lane phase timing of a single-lane subclass 1 transmitter
// assumes core_clk is the sample clock after division; sysref and sync_req_b are pins
`timescale 1ns/1ps
`default_nettype none
`include "jlt_regs.svh"

module jlt_lmfc_timing #(
    parameter int FRAMES_PER_MF = `JLT_FRAMES_PER_MF,
    parameter int LINK_DELAY = `JLT_LINK_DELAY,
    parameter int SAMPLE_W = 14
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // pins from the system
    input wire logic sysref,
    input wire logic sync_req_b,
    // configuration and samples on core_clk
    input wire logic [1:0] input_clock_divide_ratio,
    input wire logic [SAMPLE_W-1:0] sample_data,
    // timing and phase
    output logic multiframe_boundary,
    output jlt_pkg::jlt_lane_state_type lane_state,
    // delayed frame toward the serializer
    output logic [15:0] tx_frame,
    output logic [1:0] tx_is_ctrl,
    output logic tx_first_frame
);

    localparam int MFW = $clog2(FRAMES_PER_MF);
    localparam int FW = 19;
    localparam logic [MFW-1:0] MF_LAST = MFW'(FRAMES_PER_MF - 1);
    localparam logic [1:0] ILA_LAST = 2'(`JLT_ILA_MF - 1);

    if (FRAMES_PER_MF < 4 || FRAMES_PER_MF > 256) begin : g_bad_mf
        $error("frames per multiframe must be 4 to 256");
    end
    if (LINK_DELAY < `JLT_LINK_DELAY_MIN || LINK_DELAY > `JLT_LINK_DELAY_MAX) begin : g_bad_dly
        $error("link delay must lie in the output delay window");
    end
    if (SAMPLE_W > 16 || SAMPLE_W < 1) begin : g_bad_w
        $error("sample does not fit two octets");
    end

    // sysref to boundary delay in whole frame clocks, rounded up
    function automatic logic [2:0] delay_cycles(input logic [1:0] ratio);
        logic [7:0] eighths;
        eighths = `JLT_DLY8_DIV1;
        case (ratio)
            jlt_pkg::JLT_DIV1: eighths = `JLT_DLY8_DIV1;
            jlt_pkg::JLT_DIV2: eighths = `JLT_DLY8_DIV2;
            jlt_pkg::JLT_DIV4: eighths = `JLT_DLY8_DIV4;
            jlt_pkg::JLT_DIV8: eighths = `JLT_DLY8_DIV8;
            default: eighths = `JLT_DLY8_DIV1;
        endcase
        delay_cycles = 3'((eighths + `JLT_EIGHTH_ROUND) >> `JLT_EIGHTH_SHIFT);
    endfunction

    // pin synchronisers and sysref edge history
    logic sysref_meta, sysref_sync, sysref_prev;
    logic sync_meta, sync_sync;
    logic next_sysref_meta, next_sysref_sync, next_sysref_prev;
    logic next_sync_meta, next_sync_sync;
    logic sysref_rise;

    always_comb begin
        next_sysref_meta = sysref;
        next_sysref_sync = sysref_meta;
        next_sysref_prev = sysref_sync;
        next_sync_meta = sync_req_b;
        next_sync_sync = sync_meta;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sysref_meta <= 1'b0;
            sysref_sync <= 1'b0;
            sysref_prev <= 1'b0;
            sync_meta <= 1'b1;
            sync_sync <= 1'b1;
        end else begin
            sysref_meta <= next_sysref_meta;
            sysref_sync <= next_sysref_sync;
            sysref_prev <= next_sysref_prev;
            sync_meta <= next_sync_meta;
            sync_sync <= next_sync_sync;
        end
    end

    // a two-cycle high and low keeps each rise visible after the synchroniser
    assign sysref_rise = sysref_sync && !sysref_prev;

    // sysref delay counter and local multiframe counter
    logic [2:0] dly_cnt, next_dly_cnt;
    logic dly_busy, next_dly_busy;
    logic [MFW-1:0] lmfc_cnt, next_lmfc_cnt;
    logic next_boundary;
    logic force_boundary;

    always_comb begin
        next_dly_cnt = dly_cnt;
        next_dly_busy = dly_busy;
        force_boundary = dly_busy && (dly_cnt <= 3'd1);
        if (sysref_rise) begin
            next_dly_cnt = delay_cycles(input_clock_divide_ratio) - 3'd1;
            next_dly_busy = 1'b1;
        end else if (force_boundary) begin
            next_dly_busy = 1'b0;
        end else if (dly_busy) begin
            next_dly_cnt = dly_cnt - 3'd1;
        end
        // a forced boundary restarts the count from zero, unless a new sysref rise comes in the same cycle
        if (force_boundary && !sysref_rise) begin
            next_lmfc_cnt = '0;
        end else if (lmfc_cnt == MF_LAST) begin
            next_lmfc_cnt = '0;
        end else begin
            next_lmfc_cnt = lmfc_cnt + MFW'(1);
        end
        next_boundary = (next_lmfc_cnt == '0);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dly_cnt <= 3'd0;
            dly_busy <= 1'b0;
            lmfc_cnt <= MF_LAST;
            multiframe_boundary <= 1'b0;
        end else begin
            dly_cnt <= next_dly_cnt;
            dly_busy <= next_dly_busy;
            lmfc_cnt <= next_lmfc_cnt;
            multiframe_boundary <= next_boundary;
        end
    end

    // receiver sync request, accepted once held low long enough
    logic [2:0] low_cnt, next_low_cnt;
    logic sync_req;

    assign sync_req = (low_cnt == `JLT_SYNC_LOW_MIN);

    always_comb begin
        if (sync_sync) begin
            next_low_cnt = 3'd0;
        end else if (low_cnt == `JLT_SYNC_LOW_MIN) begin
            next_low_cnt = low_cnt;
        end else begin
            next_low_cnt = low_cnt + 3'd1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            low_cnt <= 3'd0;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end

    // lane phase, changed only as a boundary cycle begins
    jlt_pkg::jlt_lane_state_type next_lane_state;
    logic [1:0] ila_mf, next_ila_mf;
    logic phase_start, next_phase_start;

    always_comb begin
        next_lane_state = lane_state;
        next_ila_mf = ila_mf;
        if (next_boundary) begin
            case (lane_state)
                jlt_pkg::JLT_LINK_IDLE: begin
                    if (sync_req) begin
                        next_lane_state = jlt_pkg::JLT_LINK_CGS;
                    end
                end
                jlt_pkg::JLT_LINK_CGS: begin
                    if (sync_sync) begin
                        next_lane_state = jlt_pkg::JLT_LINK_ILA;
                        next_ila_mf = 2'd0;
                    end
                end
                jlt_pkg::JLT_LINK_ILA: begin
                    if (sync_req) begin
                        next_lane_state = jlt_pkg::JLT_LINK_CGS;
                    end else if (ila_mf == ILA_LAST) begin
                        next_lane_state = jlt_pkg::JLT_LINK_DATA;
                    end else begin
                        next_ila_mf = ila_mf + 2'd1;
                    end
                end
                jlt_pkg::JLT_LINK_DATA: begin
                    if (sync_req) begin
                        next_lane_state = jlt_pkg::JLT_LINK_CGS;
                    end
                end
                default: next_lane_state = jlt_pkg::JLT_LINK_IDLE;
            endcase
        end
        next_phase_start = (next_lane_state != lane_state);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lane_state <= jlt_pkg::JLT_LINK_IDLE;
            ila_mf <= 2'd0;
            phase_start <= 1'b0;
        end else begin
            lane_state <= next_lane_state;
            ila_mf <= next_ila_mf;
            phase_start <= next_phase_start;
        end
    end

    // frame content: one two-octet frame per sample clock
    logic [15:0] frame;
    logic [1:0] frame_ctrl;
    logic [7:0] ramp;

    always_comb begin
        ramp = 8'(lmfc_cnt);
        frame = 16'h0000;
        frame_ctrl = 2'b00;
        case (lane_state)
            jlt_pkg::JLT_LINK_CGS: begin
                frame = {`JLT_K28_5, `JLT_K28_5};
                frame_ctrl = 2'b11;
            end
            jlt_pkg::JLT_LINK_ILA: begin
                if (lmfc_cnt == '0) begin
                    frame = {`JLT_K28_0, ramp}; // multiframe start marker
                    frame_ctrl = 2'b10;
                end else if (lmfc_cnt == MF_LAST) begin
                    frame = {ramp, `JLT_K28_3}; // multiframe end marker
                    frame_ctrl = 2'b01;
                end else begin
                    frame = {ramp, ramp};
                end
            end
            jlt_pkg::JLT_LINK_DATA: begin
                // sample left-aligned in the two octets, unused low bits zero
                frame = 16'(sample_data) << (16 - SAMPLE_W);
            end
            default: frame = 16'h0000;
        endcase
    end

    // fixed boundary to output delay, the same for every phase
    logic [FW-1:0] tx_word;

    jlt_frame_delay #(
        .WIDTH(FW),
        .DEPTH(LINK_DELAY)
    ) u_delay (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .din({phase_start, frame_ctrl, frame}),
        .dout(tx_word)
    );

    assign tx_first_frame = tx_word[18];
    assign tx_is_ctrl = tx_word[17:16];
    assign tx_frame = tx_word[15:0];

    // checks on the timing relations
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_clean_sysref;
        sysref_rise ##1 (!sysref_rise) [*3];
    endsequence

    sequence s_enter(jlt_pkg::jlt_lane_state_type st);
        phase_start && multiframe_boundary && lane_state == st;
    endsequence

    a_sysref_to_boundary: assert property (s_clean_sysref |=> multiframe_boundary && lmfc_cnt == '0)
        else $error("boundary not four frames after sysref");
    a_sysref_restart: assert property (sysref_rise |=> dly_busy && dly_cnt == 3'd3)
        else $error("sysref rise did not restart delay");
    a_lmfc_wrap: assert property (lmfc_cnt == MF_LAST && !dly_busy |=> multiframe_boundary)
        else $error("multiframe counter did not wrap");
    a_first_cgs_out: assert property (s_enter(jlt_pkg::JLT_LINK_CGS) |-> ##LINK_DELAY (tx_first_frame && tx_is_ctrl == 2'b11))
        else $error("first K28.5 frame late or early");
    a_first_ila_out: assert property (s_enter(jlt_pkg::JLT_LINK_ILA) |-> ##LINK_DELAY (tx_first_frame && tx_frame[15:8] == `JLT_K28_0))
        else $error("first alignment frame misplaced");
    a_first_data_out: assert property (s_enter(jlt_pkg::JLT_LINK_DATA) |-> ##LINK_DELAY (tx_first_frame && tx_is_ctrl == 2'b00))
        else $error("first data frame misplaced");
    a_data_sample: assert property (s_enter(jlt_pkg::JLT_LINK_DATA) |-> ##LINK_DELAY (tx_frame[15:16-SAMPLE_W] == $past(sample_data, LINK_DELAY)))
        else $error("first data sample not the boundary sample");
    a_ila_length: assert property (s_enter(jlt_pkg::JLT_LINK_DATA) |-> $past(lane_state) == jlt_pkg::JLT_LINK_ILA && ila_mf == ILA_LAST)
        else $error("alignment sequence not four multiframes");
    a_sync_hold: assert property ($rose(sync_req) |-> !$past(sync_sync, 1) && !$past(sync_sync, 4))
        else $error("sync request taken before four low frames");
    a_phase_on_boundary: assert property ($changed(lane_state) |-> multiframe_boundary)
        else $error("lane phase changed off a boundary");

endmodule // jlt_lmfc_timing

`default_nettype wire

// ==== hdl/jlt_regs.svh ====
// constants for the multiframe timing block: delays, counts and control characters
// assumes the frame clock is core_clk itself, so a frame clock cycle is one core_clk cycle
`ifndef JLT_REGS_SVH
`define JLT_REGS_SVH

// sysref to multiframe delay per divide ratio, in eighths of a frame clock cycle
`define JLT_DLY8_DIV1 8'd28
`define JLT_DLY8_DIV2 8'd32
`define JLT_DLY8_DIV4 8'd30
`define JLT_DLY8_DIV8 8'd29
// rounding of an eighths figure up to whole frame clock cycles
`define JLT_EIGHTH_ROUND 8'd7
`define JLT_EIGHTH_SHIFT 3

// boundary to serial output delay window and chosen figure, frame clock cycles
`define JLT_LINK_DELAY_MIN 7
`define JLT_LINK_DELAY_MAX 9
`define JLT_LINK_DELAY 8

// frames in one multiframe
`define JLT_FRAMES_PER_MF 32
// length of the lane alignment sequence, multiframes
`define JLT_ILA_MF 4
// least low time of the receiver's sync request, frame clock cycles
`define JLT_SYNC_LOW_MIN 3'd4
// least high and low time of sysref, frame clock cycles
`define JLT_SYSREF_MIN 2

// control characters placed in the octet stream
`define JLT_K28_5 8'hbc
`define JLT_K28_0 8'h1c
`define JLT_K28_3 8'h7c

`endif

// ==== hdl/jlt_pkg.sv ====
// types shared by the multiframe timing block
// assumes nothing beyond a SystemVerilog compiler
package jlt_pkg;

    // link phase of the single lane
    typedef enum logic [1:0] {
        JLT_LINK_IDLE = 2'b00,
        JLT_LINK_CGS = 2'b01,
        JLT_LINK_ILA = 2'b10,
        JLT_LINK_DATA = 2'b11
    } jlt_lane_state_type;

    // input clock divide ratio selection
    typedef enum logic [1:0] {
        JLT_DIV1 = 2'b00,
        JLT_DIV2 = 2'b01,
        JLT_DIV4 = 2'b10,
        JLT_DIV8 = 2'b11
    } jlt_div_type;

endpackage

// ==== hdl/jlt_frame_delay.sv ====
// fixed-length frame delay line between frame build and serial output
// assumes one frame enters every clock; output comes from the last flip-flop stage
`timescale 1ns/1ps
`default_nettype none

module jlt_frame_delay #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // frame stream
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_shape
        $error("frame delay needs positive width and depth");
    end

    logic [WIDTH-1:0] stage [DEPTH];
    logic [WIDTH-1:0] next_stage [DEPTH];

    // shift each frame one stage per clock
    always_comb begin
        next_stage[0] = din;
        for (int i = 1; i < DEPTH; i++) begin
            next_stage[i] = stage[i-1];
        end
    end

    // stage registers, cleared by reset
    genvar g;
    for (g = 0; g < DEPTH; g++) begin : g_stage
        always_ff @(posedge core_clk) begin
            if (!rst_b) begin
                stage[g] <= '0;
            end else begin
                stage[g] <= next_stage[g];
            end
        end
    end

    assign dout = stage[DEPTH-1];

endmodule // jlt_frame_delay

`default_nettype wire

// ==== testbench/jlt_link_partner.sv ====
// model of the clock source and link receiver facing the timing block
// assumes pins change on the falling edge of core_clk, the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none

module jlt_link_partner (
    // frame clock
    input wire logic core_clk,
    // pins toward the device
    output logic sysref,
    output logic sync_req_b
);
    // idle levels: no sysref, no sync request
    initial begin
        sysref = 1'b0;
        sync_req_b = 1'b1;
    end

    // one sysref pulse, never shorter than two frame clocks high or low
    task automatic pulse_sysref(input int hi, input int lo);
        @(negedge core_clk) sysref <= 1'b1;
        repeat ((hi < 2) ? 2 : hi) @(negedge core_clk);
        sysref <= 1'b0;
        repeat ((lo < 2) ? 2 : lo) @(negedge core_clk);
    endtask

    // hold the sync request at a level until told otherwise
    task automatic drive_sync(input logic lvl);
        @(negedge core_clk) sync_req_b <= lvl;
    endtask

    // low pulse of a given length; four or more asks for resync
    task automatic pulse_sync(input int len);
        @(negedge core_clk) sync_req_b <= 1'b0;
        repeat (len) @(negedge core_clk);
        sync_req_b <= 1'b1;
    endtask
endmodule // jlt_link_partner

`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench of the multiframe timing and lane phase block
// assumes the partner model drives the pins and the bench the samples and ratio
`timescale 1ns/1ps
`default_nettype none
`include "jlt_regs.svh"

module tb;
    localparam int FPM = 16;
    logic core_clk;
    logic rst_b;
    logic sysref;
    logic sync_req_b;
    logic [1:0] input_clock_divide_ratio;
    logic [13:0] sample_data;
    logic multiframe_boundary;
    jlt_pkg::jlt_lane_state_type lane_state;
    logic [15:0] tx_frame;
    logic [1:0] tx_is_ctrl;
    logic tx_first_frame;
    int errors = 0;
    int compares = 0;
    int seed = 57;
    int cyc = 0;
    int rise_cyc = 0;
    logic sysref_q = 1'b0;
    logic [13:0] bnd_smp = 14'h0000;
    int c0, c1;

    jlt_lmfc_timing #(.FRAMES_PER_MF(FPM)) u_jlt_lmfc_timing (
        .core_clk(core_clk), .rst_b(rst_b), .sysref(sysref), .sync_req_b(sync_req_b),
        .input_clock_divide_ratio(input_clock_divide_ratio), .sample_data(sample_data),
        .multiframe_boundary(multiframe_boundary), .lane_state(lane_state),
        .tx_frame(tx_frame), .tx_is_ctrl(tx_is_ctrl), .tx_first_frame(tx_first_frame));

    jlt_link_partner u_jlt_link_partner (
        .core_clk(core_clk), .sysref(sysref), .sync_req_b(sync_req_b));

    // 20 mhz frame clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // random samples every frame
    always @(negedge core_clk) begin
        sample_data <= 14'($random(seed));
    end

    // cycle count, sysref rise time at the pin, sample held at each boundary
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        sysref_q <= sysref;
        if (sysref && !sysref_q) rise_cyc <= cyc;
        if (multiframe_boundary) bnd_smp <= sample_data;
    end

    // expected control flags and frame for the first frame of a phase
    function automatic logic [17:0] exp_frame(jlt_pkg::jlt_lane_state_type s, logic [13:0] smp);
        case (s)
            jlt_pkg::JLT_LINK_CGS: return {2'b11, `JLT_K28_5, `JLT_K28_5};
            jlt_pkg::JLT_LINK_ILA: return {2'b10, `JLT_K28_0, 8'h00};
            jlt_pkg::JLT_LINK_DATA: return {2'b00, smp, 2'b00};
            default: return 18'h00000;
        endcase
    endfunction

    // compare of frame-sized values
    task automatic check_frame(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare of counts and flags
    task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // wait at falling edges for a boundary, optionally in a given phase
    task automatic wait_bnd(input logic any, input jlt_pkg::jlt_lane_state_type s, output int c);
        int n;
        for (n = 0; n < 10 * FPM; n++) begin
            @(negedge core_clk);
            if (multiframe_boundary === 1'b1 && (any || lane_state === s)) break;
        end
        if (n == 10 * FPM) errors++;
        c = cyc;
    endtask

    // phase entry at a boundary, then its first frame at the output
    task automatic phase_check(input jlt_pkg::jlt_lane_state_type s, output int c);
        wait_bnd(1'b0, s, c);
        repeat (`JLT_LINK_DELAY) @(posedge core_clk);
        @(negedge core_clk);
        check_frame({tx_is_ctrl, tx_frame}, exp_frame(s, bnd_smp));
        check_num(tx_first_frame, 1);
    endtask

    // closing report and verdict
    task automatic give_verdict;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #(50 * 20000);
        errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        input_clock_divide_ratio = 2'b00;
        repeat (2) @(negedge core_clk);
        rst_b <= 1'b1;
        wait_bnd(1'b1, jlt_pkg::JLT_LINK_IDLE, c0);
        wait_bnd(1'b1, jlt_pkg::JLT_LINK_IDLE, c1);
        check_num(c1 - c0, FPM);
        check_num(lane_state, jlt_pkg::JLT_LINK_IDLE);
        $display("test free-running boundary done");
        // every ratio, random pulse widths; boundary fixed after the rise
        for (int r = 0; r < 4; r++) begin
            input_clock_divide_ratio <= r[1:0];
            fork
                u_jlt_link_partner.pulse_sysref(2 + $unsigned($random(seed)) % 4,
                    2 + $unsigned($random(seed)) % 4);
                begin
                    @(posedge core_clk);
                    do wait_bnd(1'b1, jlt_pkg::JLT_LINK_IDLE, c0); while (c0 < rise_cyc + 6);
                end
            join
            // two synchroniser stages, then four frames of boundary delay
            check_num(c0 - rise_cyc, 6);
            wait_bnd(1'b1, jlt_pkg::JLT_LINK_IDLE, c1);
            check_num(c1 - c0, FPM);
        end
        $display("test sysref alignment done");
        u_jlt_link_partner.drive_sync(1'b0);
        phase_check(jlt_pkg::JLT_LINK_CGS, c0);
        u_jlt_link_partner.drive_sync(1'b1);
        phase_check(jlt_pkg::JLT_LINK_ILA, c0);
        phase_check(jlt_pkg::JLT_LINK_DATA, c1);
        check_num(c1 - c0, 4 * FPM);
        $display("test link start done");
        // a short request is ignored, a held one forces resync
        u_jlt_link_partner.pulse_sync(3);
        repeat (3 * FPM) @(negedge core_clk);
        check_num(lane_state, jlt_pkg::JLT_LINK_DATA);
        u_jlt_link_partner.drive_sync(1'b0);
        phase_check(jlt_pkg::JLT_LINK_CGS, c0);
        u_jlt_link_partner.drive_sync(1'b1);
        $display("test resync done");
        give_verdict();
    end
endmodule // tb

`default_nettype wire
